// ---- core/pld_pkg.sv ----
// Purpose: Shared constants and types for the macrocell register core.
// Assumes: APB register access at 25 MHz, 32-bit data, byte addresses.
// Notes:   Mode and cell codes are the values software writes to the control fields.
package pld_pkg;

    // Clock rate and power-up reset interval
    localparam int unsigned CLK_MHZ                = 25;
    localparam int unsigned POWER_UP_RESET_TIME_NS = 1000;
    localparam int unsigned POR_RAW = (POWER_UP_RESET_TIME_NS * CLK_MHZ) / 1000;
    localparam int unsigned POR_CYC = (POR_RAW > 0) ? POR_RAW : 1;

    // Register byte addresses
    localparam logic [7:0] A_CTRL    = 8'h00;
    localparam logic [7:0] A_CFG     = 8'h04;
    localparam logic [7:0] A_PRELOAD = 8'h08;
    localparam logic [7:0] A_STATUS  = 8'h0C;
    localparam logic [7:0] A_SIG_LO  = 8'h10;
    localparam logic [7:0] A_SIG_HI  = 8'h14;

    // Field positions
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_FUSE_BIT = 8;
    localparam int unsigned PRE_VAL_LSB   = 0;
    localparam int unsigned PRE_MASK_LSB  = 8;
    localparam int unsigned ST_REG_LSB    = 0;
    localparam int unsigned ST_OUT_LSB    = 8;
    localparam int unsigned ST_SEC_BIT    = 16;
    localparam int unsigned ST_POR_BIT    = 17;
    localparam int unsigned ST_MODE_LSB   = 18;

    // Macrocells whose pins lose feedback in some modes
    localparam int unsigned CELL_OUTER_LO = 0;
    localparam int unsigned CELL_OUTER_HI = 7;
    localparam int unsigned CELL_CENTER_A = 3;
    localparam int unsigned CELL_CENTER_B = 4;

    typedef enum logic [1:0] {
        MODE_REG     = 2'h0,
        MODE_COMPLEX = 2'h1,
        MODE_SIMPLE  = 2'h2
    } mode_e;
    localparam logic [1:0] MODE_BAD = 2'h3;

    typedef enum logic [1:0] {
        MC_REG_OUT  = 2'h0,
        MC_COMB_IO  = 2'h1,
        MC_COMB_OUT = 2'h2,
        MC_INPUT    = 2'h3
    } cell_e;

    typedef enum logic [1:0] {
        PR_CLEAR = 2'b01,
        PR_RUN   = 2'b10
    } por_e;

    // Reset values
    localparam logic [15:0] CFG_RST = 16'h0000;
    localparam logic [7:0]  OUT_RST = 8'hFF;

    typedef struct packed {
        logic       clk;
        logic       oe_n;
        logic [7:0] in;
        logic [7:0] io;
    } pins_s;

    // Filter reset matches the idle pins, so floating inputs never read low after reset
    localparam pins_s PIN_RST = '{clk: 1'b0, oe_n: 1'b0, in: 8'hFF, io: 8'hFF};

endpackage

// ---- core/pld_reg_core.sv ----
// Purpose: Macrocell registers with power-up clear, preload, security fuse and signature.
// Assumes: Board pins are asynchronous and sampled on pclk; the product-term array is
//          outside and hands in one sum term and one enable term per macrocell.
// Notes:   Registers advance on a filtered rising edge of the clock pin, not on pclk.
// Behaviour
// (RULE_01) Power-up asynchronously clears every macrocell register low.
// (RULE_02) Inverting register path makes registered outputs high after power-up reset.
// (RULE_03) Board meets input and feedback setup before first clock edge.
// (RULE_04) Board keeps clock pin still during power-up reset, at most 1000 ns.
// (RULE_05) Preload forces each register individually high or low.
// (RULE_06) Programmed security fuse refuses configuration readback and preload at once.
// (RULE_07) 64-bit user signature stays readable whether or not secured.
// (RULE_08) Programmer should set the security fuse last.
// (RULE_09) Each macrocell is registered, combinatorial I/O, combinatorial output or input.
// (RULE_10) Device runs in exactly one of three architecture modes.
// (RULE_11) Undriven input or I/O pins look high to the array.
// (RULE_12) Registered mode: common clock pin clocks, common active-low enable gates outputs.
// (RULE_13) Registered mode combinatorial cell: product-term enable, seven-term sum.
// (RULE_14) Power-up reset is an async clear held for the interval, then released.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/100ps
module pld_reg_core #(
    parameter int unsigned POR_CYCLES = pld_pkg::POR_CYC
) (
    // Clock and reset
    input  logic        pclk,
    input  logic        presetn,
    // APB slave
    input  logic        psel,
    input  logic        penable,
    input  logic        pwrite,
    input  logic [7:0]  paddr,
    input  logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic        pready,
    output logic        pslverr,
    // Board pins
    input  logic        clk_pin,
    input  logic        oe_n_pin,
    input  logic [7:0]  in_pin,
    input  logic [7:0]  in_driven,
    input  logic [7:0]  io_in,
    input  logic [7:0]  io_driven,
    output logic [7:0]  io_out,
    output logic [7:0]  io_oe,
    // Product-term array
    input  logic [7:0]  sum_term,
    input  logic [7:0]  pterm_oe,
    output logic [15:0] array_in,
    output logic        por_busy
);

    if (POR_CYCLES < 1 || POR_CYCLES > 65535) begin : g_chk
        $error("POR_CYCLES out of range");
    end

    // Bits that agree in the last two stages are taken, others keep their value
    function automatic pld_pkg::pins_s settle(pld_pkg::pins_s a, pld_pkg::pins_s b,
                                              pld_pkg::pins_s keep);
        return pld_pkg::pins_s'((~(a ^ b) & b) | ((a ^ b) & keep));
    endfunction

    function automatic logic bus_err(logic [7:0] a, logic wr, logic sec, logic [1:0] md);
        logic e;
        e = 1'b0;
        case (a)
            pld_pkg::A_CTRL:    e = (sec & ~wr) | (wr & (md == pld_pkg::MODE_BAD)); // RULE_06 RULE_10
            pld_pkg::A_CFG:     e = sec & ~wr; // RULE_06
            pld_pkg::A_PRELOAD: e = sec; // RULE_06
            pld_pkg::A_STATUS:  e = wr;
            pld_pkg::A_SIG_LO,
            pld_pkg::A_SIG_HI:  e = 1'b0; // RULE_07
            default:            e = 1'b1;
        endcase
        return e;
    endfunction

    pld_pkg::pins_s raw, f1_q, f2_q, f3_q, pin_q, pin_d;
    pld_pkg::por_e  por_q, por_d;
    logic [15:0]    cnt_q, cnt_d;
    pld_pkg::mode_e mode_q, mode_d;
    logic [15:0]    cfg_q, cfg_d;
    logic           fuse_q, fuse_d;
    logic [63:0]    sig_q, sig_d;
    logic [31:0]    prdata_q, prdata_d;
    logic [7:0]     reg_q, reg_d;
    logic [7:0]     out_q, out_d, oe_q, oe_d;
    logic [15:0]    ain_q, ain_d;
    logic [7:0]     reg_cells, pre_val, pre_mask;
    logic           clk_rise, err, access, wr_ok, pre_hit;

    // Undriven pins float high through the pull-ups; our own drive counts as a driver
    always_comb begin
        raw.clk  = clk_pin;
        raw.oe_n = oe_n_pin;
        raw.in   = in_pin | ~in_driven; // RULE_11
        raw.io   = io_in | ~(io_driven | oe_q); // RULE_11
        pin_d    = settle(f2_q, f3_q, pin_q);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            f1_q  <= pld_pkg::PIN_RST; // RULE_11
            f2_q  <= pld_pkg::PIN_RST;
            f3_q  <= pld_pkg::PIN_RST;
            pin_q <= pld_pkg::PIN_RST;
        end else begin
            f1_q  <= raw;
            f2_q  <= f1_q;
            f3_q  <= f2_q;
            pin_q <= pin_d;
        end
    end

    // Edges seen while reset is held are dropped, which tolerates a noisy board clock
    assign clk_rise = pin_d.clk & ~pin_q.clk; // RULE_12

    // Power-up interval: registers stay cleared until the count expires
    always_comb begin
        por_d = por_q;
        cnt_d = cnt_q;
        unique case (por_q)
            pld_pkg::PR_CLEAR: begin
                if (cnt_q == 16'(POR_CYCLES - 1)) begin
                    por_d = pld_pkg::PR_RUN; // RULE_14
                end else begin
                    cnt_d = cnt_q + 16'h0001;
                end
            end
            pld_pkg::PR_RUN: begin
                cnt_d = cnt_q;
            end
            default: begin
                por_d = pld_pkg::PR_CLEAR;
                cnt_d = '0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_q <= pld_pkg::PR_CLEAR; // RULE_14
            cnt_q <= '0;
        end else begin
            por_q <= por_d;
            cnt_q <= cnt_d;
        end
    end

    assign por_busy = (por_q == pld_pkg::PR_CLEAR);

    // APB: read data is captured in the setup cycle, so the slave never waits
    assign pre_val  = pwdata[pld_pkg::PRE_VAL_LSB +: 8];
    assign pre_mask = pwdata[pld_pkg::PRE_MASK_LSB +: 8];
    assign err      = bus_err(paddr, pwrite, fuse_q, pwdata[pld_pkg::CTRL_MODE_LSB +: 2]);
    assign access   = psel & penable;
    assign wr_ok    = access & pwrite & ~err;
    assign pre_hit  = wr_ok & (paddr == pld_pkg::A_PRELOAD);
    assign pready   = 1'b1;
    assign pslverr  = access & err;
    assign prdata   = prdata_q;

    always_comb begin
        mode_d   = mode_q;
        cfg_d    = cfg_q;
        fuse_d   = fuse_q;
        sig_d    = sig_q;
        prdata_d = prdata_q;
        if (psel && !penable) begin
            prdata_d = '0;
            if (!pwrite && !err) begin
                case (paddr)
                    pld_pkg::A_CTRL: begin
                        prdata_d[pld_pkg::CTRL_MODE_LSB +: 2] = mode_q;
                        prdata_d[pld_pkg::CTRL_FUSE_BIT]      = fuse_q;
                    end
                    pld_pkg::A_CFG: prdata_d[15:0] = cfg_q;
                    pld_pkg::A_STATUS: begin
                        prdata_d[pld_pkg::ST_REG_LSB +: 8]  = reg_q;
                        prdata_d[pld_pkg::ST_OUT_LSB +: 8]  = out_q;
                        prdata_d[pld_pkg::ST_SEC_BIT]       = fuse_q;
                        prdata_d[pld_pkg::ST_POR_BIT]       = por_busy;
                        prdata_d[pld_pkg::ST_MODE_LSB +: 2] = mode_q;
                    end
                    pld_pkg::A_SIG_LO: prdata_d = sig_q[31:0]; // RULE_07
                    pld_pkg::A_SIG_HI: prdata_d = sig_q[63:32]; // RULE_07
                    default: prdata_d = '0;
                endcase
            end
        end
        if (wr_ok) begin
            case (paddr)
                pld_pkg::A_CTRL: begin
                    mode_d = pld_pkg::mode_e'(pwdata[pld_pkg::CTRL_MODE_LSB +: 2]); // RULE_10
                    // The fuse only sets; protection applies from the next access
                    fuse_d = fuse_q | pwdata[pld_pkg::CTRL_FUSE_BIT]; // RULE_06
                end
                pld_pkg::A_CFG:    cfg_d = pwdata[15:0]; // RULE_09
                pld_pkg::A_SIG_LO: sig_d[31:0] = pwdata;
                pld_pkg::A_SIG_HI: sig_d[63:32] = pwdata;
                default: sig_d = sig_q;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q   <= pld_pkg::MODE_REG;
            cfg_q    <= pld_pkg::CFG_RST;
            fuse_q   <= 1'b0;
            sig_q    <= '0;
            prdata_q <= '0;
        end else begin
            mode_q   <= mode_d;
            cfg_q    <= cfg_d;
            fuse_q   <= fuse_d;
            sig_q    <= sig_d;
            prdata_q <= prdata_d;
        end
    end

    // Macrocells: registers, output drive and feedback into the array
    always_comb begin
        pld_pkg::cell_e c;
        logic           edge_cell, no_fb;
        c         = pld_pkg::MC_REG_OUT;
        edge_cell = 1'b0;
        no_fb     = 1'b0;
        reg_d     = reg_q;
        out_d = out_q;
        oe_d  = '0;
        ain_d = {8'h00, pin_q.in};
        for (int i = 0; i < 8; i++) begin
            c            = pld_pkg::cell_e'(cfg_q[2*i +: 2]);
            reg_cells[i] = (mode_q == pld_pkg::MODE_REG) && (c == pld_pkg::MC_REG_OUT);
            edge_cell    = (i == pld_pkg::CELL_OUTER_LO) || (i == pld_pkg::CELL_OUTER_HI);
            no_fb        = 1'b0;
            out_d[i]     = sum_term[i];
            if (clk_rise && reg_cells[i]) begin
                reg_d[i] = sum_term[i]; // RULE_12
            end
            unique case (mode_q)
                pld_pkg::MODE_REG: begin
                    if (c == pld_pkg::MC_REG_OUT) begin
                        out_d[i] = ~reg_q[i]; // RULE_02
                        oe_d[i]  = ~pin_q.oe_n; // RULE_12
                    end else if (c != pld_pkg::MC_INPUT) begin
                        oe_d[i] = pterm_oe[i]; // RULE_13
                    end
                end
                pld_pkg::MODE_COMPLEX: begin
                    oe_d[i] = (c != pld_pkg::MC_INPUT || edge_cell) ? pterm_oe[i] : 1'b0;
                    no_fb   = edge_cell;
                end
                pld_pkg::MODE_SIMPLE: begin
                    no_fb   = (i == pld_pkg::CELL_CENTER_A) || (i == pld_pkg::CELL_CENTER_B);
                    oe_d[i] = no_fb || (c != pld_pkg::MC_INPUT); // RULE_09
                end
                default: oe_d[i] = 1'b0;
            endcase
            ain_d[8 + i] = reg_cells[i] ? ~reg_q[i] : (no_fb | pin_q.io[i]);
        end
        if (pre_hit) begin
            reg_d = (reg_q & ~pre_mask) | (pre_val & pre_mask); // RULE_05
        end
        if (por_busy) begin
            reg_d = '0; // RULE_01 RULE_04
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reg_q <= '0; // RULE_01
            out_q <= pld_pkg::OUT_RST; // RULE_02
            oe_q  <= '0;
            ain_q <= '1;
        end else begin
            reg_q <= reg_d;
            out_q <= out_d;
            oe_q  <= oe_d;
            ain_q <= ain_d;
        end
    end

    assign io_out   = out_q;
    assign io_oe    = oe_q;
    assign array_in = ain_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence preload_write;
        psel && penable && pwrite && (paddr == pld_pkg::A_PRELOAD) && !fuse_q && !por_busy;
    endsequence

    sequence secured_access;
        fuse_q && psel && penable && (paddr == pld_pkg::A_PRELOAD ||
            (!pwrite && (paddr == pld_pkg::A_CFG || paddr == pld_pkg::A_CTRL)));
    endsequence

    sequence in0_floating;
        (!in_driven[0])[*6];
    endsequence

    por_clear_a: assert property (por_busy |-> reg_q == 8'h00) // RULE_01
        else $error("register not cleared during power-up");
    por_len_a: assert property ($fell(por_busy) |-> $past(cnt_q) == 16'(POR_CYCLES - 1)) // RULE_14
        else $error("power-up interval wrong length");
    out_high_a: assert property (por_busy [*2] |-> (out_q | ~reg_cells) == 8'hFF) // RULE_02
        else $error("registered output not high after power-up");
    reg_hold_a: assert property (!clk_rise && !pre_hit && !por_busy |=> $stable(reg_q)) // RULE_12
        else $error("register changed without a clock edge");
    preload_a: assert property (preload_write |=> // RULE_05
            (reg_q & $past(pre_mask)) == ($past(pre_val) & $past(pre_mask)))
        else $error("preload value not loaded");
    sec_refuse_a: assert property (secured_access |-> pslverr ##1 fuse_q) // RULE_06
        else $error("secured access not refused");
    sig_read_a: assert property (psel && penable && !pwrite && paddr == pld_pkg::A_SIG_HI // RULE_07
            |-> !pslverr && prdata == sig_q[63:32])
        else $error("signature not readable");
    mode_bad_a: assert property (psel && penable && pwrite && paddr == pld_pkg::A_CTRL && // RULE_10
            pwdata[pld_pkg::CTRL_MODE_LSB +: 2] == pld_pkg::MODE_BAD |-> pslverr ##1 $stable(mode_q))
        else $error("illegal mode accepted");
    pullup_a: assert property (in0_floating |=> array_in[0]) // RULE_11
        else $error("floating input not seen high");

endmodule

// ---- dv/board_model.sv ----
// Purpose: Board logic around the core: clock pin, output enable, inputs, I/O pins.
// Assumes: Pins change right after a pclk edge; the clock pin only moves in pulse().
// Notes:   Floating inputs and I/O pins sit at the pull-up level.
`timescale 1ns/100ps
module board_model (
    // Clock
    input  wire logic       pclk,
    // Board pins into the core
    output logic            clk_pin,
    output logic            oe_n_pin,
    output logic      [7:0] in_pin,
    output logic      [7:0] in_driven,
    output logic      [7:0] io_in,
    output logic      [7:0] io_driven,
    // Core drive of the I/O pins
    input  wire logic [7:0] io_out,
    input  wire logic [7:0] io_oe
);
    logic [7:0] in_val;
    logic [7:0] io_val;

    initial begin
        clk_pin   = 1'b0;
        oe_n_pin  = 1'b0;
        in_val    = 8'h00;
        io_val    = 8'h00;
        in_driven = 8'h00;
        io_driven = 8'h00;
    end

    // Released inputs go to the pull-up level
    assign in_pin = (in_driven & in_val) | ~in_driven;
    // Wire level: core drive, else board drive, else the pull-up
    assign io_in  = (io_oe & io_out) | (~io_oe & io_driven & io_val) | (~io_oe & ~io_driven);

    task automatic drive_in(input logic [7:0] drv, input logic [7:0] val);
        @(posedge pclk);
        in_driven <= drv;
        in_val    <= val;
        io_driven <= drv;
        io_val    <= val;
    endtask

    task automatic set_oe(input logic v);
        @(posedge pclk);
        oe_n_pin <= v;
    endtask

    // Both levels held long enough for the pin filter; still between pulses
    task automatic pulse();
        @(posedge pclk);
        clk_pin <= 1'b1;
        repeat (6) @(posedge pclk);
        clk_pin <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask
endmodule

// ---- dv/tb.sv ----
// Purpose: Self-checking bench for the macrocell register core.
// Assumes: Short power-up interval of 2 cycles; board_model drives the pins.
// Notes:   Register cases run from a table; reset, modes and the fuse are hand-written.
`timescale 1ns/100ps
module tb;
    localparam int unsigned POR = 2;
    typedef struct packed {
        logic        w;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] x;
        logic        e;
    } row_s;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, clk_pin, oe_n_pin;
    logic        por_busy, erv;
    logic [7:0]  paddr, in_pin, in_driven, io_in, io_driven, io_out, io_oe, sum_term, pterm_oe;
    logic [31:0] pwdata, prdata, rdv;
    logic [15:0] array_in;
    int          err_count, num_checks;
    row_s        rows [13];

    pld_reg_core #(.POR_CYCLES(POR)) i_pld_reg_core (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .clk_pin(clk_pin), .oe_n_pin(oe_n_pin),
        .in_pin(in_pin), .in_driven(in_driven), .io_in(io_in), .io_driven(io_driven),
        .io_out(io_out), .io_oe(io_oe), .sum_term(sum_term), .pterm_oe(pterm_oe),
        .array_in(array_in), .por_busy(por_busy)
    );
    board_model i_board_model (
        .pclk(pclk), .clk_pin(clk_pin), .oe_n_pin(oe_n_pin), .in_pin(in_pin),
        .in_driven(in_driven), .io_in(io_in), .io_driven(io_driven),
        .io_out(io_out), .io_oe(io_oe)
    );

    initial pclk = 1'b0;
    always #20 pclk = ~pclk;

    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdv = prdata;
        erv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Whole run is near 175 cycles; this allows over eighty times that
    initial begin
        #600000;
        err_count++;
        give_verdict();
    end

    initial begin
        err_count = 0;
        num_checks = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        sum_term = 8'h00;
        pterm_oe = 8'h00;
        rows = '{
            '{1'b1, pld_pkg::A_CFG, 32'h00001234, 32'h00000000, 1'b0},
            '{1'b0, pld_pkg::A_CFG, 32'h00000000, 32'h00001234, 1'b0},
            '{1'b1, pld_pkg::A_SIG_LO, 32'h89ABCDEF, 32'h00000000, 1'b0},
            '{1'b1, pld_pkg::A_SIG_HI, 32'h01234567, 32'h00000000, 1'b0},
            '{1'b0, pld_pkg::A_SIG_LO, 32'h00000000, 32'h89ABCDEF, 1'b0},
            '{1'b0, pld_pkg::A_SIG_HI, 32'h00000000, 32'h01234567, 1'b0},
            '{1'b1, 8'h18, 32'hFFFFFFFF, 32'h00000000, 1'b1},
            '{1'b0, 8'h18, 32'h00000000, 32'h00000000, 1'b1},
            '{1'b1, pld_pkg::A_STATUS, 32'h00000000, 32'h00000000, 1'b1},
            '{1'b1, pld_pkg::A_CTRL, 32'h00000003, 32'h00000000, 1'b1},
            '{1'b0, pld_pkg::A_CTRL, 32'h00000000, 32'h00000000, 1'b0},
            '{1'b1, pld_pkg::A_CTRL, 32'h00000001, 32'h00000000, 1'b0},
            '{1'b0, pld_pkg::A_CTRL, 32'h00000000, 32'h00000001, 1'b0}
        };
        repeat (3) @(posedge pclk);
        chk("io_out", 32'h000000FF, 32'(io_out));
        chk("io_oe", 32'h00000000, 32'(io_oe));
        presetn <= 1'b1;
        @(posedge pclk);
        chk("por_busy", 32'h00000001, 32'(por_busy));
        repeat (POR + 2) @(posedge pclk);
        chk("por_busy", 32'h00000000, 32'(por_busy));
        apb(1'b0, pld_pkg::A_STATUS, 32'h00000000);
        chk("status", 32'h0000FF00, rdv);
        i_board_model.drive_in(8'h00, 8'h00);
        repeat (8) @(posedge pclk);
        chk("array_in", 32'h000000FF, 32'(array_in[7:0]));
        i_board_model.drive_in(8'hFF, 8'h5A);
        repeat (8) @(posedge pclk);
        chk("array_in", 32'h0000005A, 32'(array_in[7:0]));
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk("pslverr", 32'(rows[i].e), 32'(erv));
            if (!rows[i].w) chk("prdata", rows[i].x, rdv);
        end
        // Registered cells follow the clock pin, outputs gated by the enable pin
        apb(1'b1, pld_pkg::A_CFG, 32'h00000000);
        apb(1'b1, pld_pkg::A_CTRL, 32'h00000000);
        sum_term <= 8'h3C;
        i_board_model.pulse();
        apb(1'b0, pld_pkg::A_STATUS, 32'h00000000);
        chk("status", 32'h0000C33C, rdv);
        chk("feedback", 32'h000000C3, 32'(array_in[15:8]));
        chk("io_oe", 32'h000000FF, 32'(io_oe));
        i_board_model.set_oe(1'b1);
        repeat (6) @(posedge pclk);
        chk("io_oe", 32'h00000000, 32'(io_oe));
        apb(1'b1, pld_pkg::A_PRELOAD, 32'h0000FFA5);
        apb(1'b0, pld_pkg::A_STATUS, 32'h00000000);
        chk("status", 32'h00005AA5, rdv);
        apb(1'b1, pld_pkg::A_PRELOAD, 32'h00000F00);
        apb(1'b0, pld_pkg::A_STATUS, 32'h00000000);
        chk("status", 32'h00005FA0, rdv);
        // Cells 1 and 2 combinatorial, cell 3 input, in registered mode
        i_board_model.set_oe(1'b0);
        sum_term <= 8'h06;
        pterm_oe <= 8'h02;
        apb(1'b1, pld_pkg::A_CFG, 32'h000000E4);
        repeat (6) @(posedge pclk);
        chk("io_oe", 32'h000000F3, 32'(io_oe));
        chk("io_out", 32'h00000006, 32'(io_out & 8'h06));
        // Complex then simple mode: no register clocks, cell 5 input
        pterm_oe <= 8'h0F;
        apb(1'b1, pld_pkg::A_CFG, 32'h00000C00);
        apb(1'b1, pld_pkg::A_CTRL, 32'h00000001);
        sum_term <= 8'hFF;
        i_board_model.pulse();
        chk("io_oe", 32'h0000000F, 32'(io_oe));
        apb(1'b0, pld_pkg::A_STATUS, 32'h00000000);
        chk("status", 32'h000400A0, rdv & 32'h000C00FF);
        apb(1'b1, pld_pkg::A_CTRL, 32'h00000002);
        repeat (6) @(posedge pclk);
        chk("io_oe", 32'h000000DF, 32'(io_oe));
        // Fuse goes last since it locks at once
        apb(1'b1, pld_pkg::A_CTRL, 32'h00000100);
        apb(1'b0, pld_pkg::A_CFG, 32'h00000000);
        chk("pslverr", 32'h00000001, 32'(erv));
        chk("prdata", 32'h00000000, rdv);
        apb(1'b1, pld_pkg::A_PRELOAD, 32'h0000FFFF);
        chk("pslverr", 32'h00000001, 32'(erv));
        apb(1'b0, pld_pkg::A_SIG_HI, 32'h00000000);
        chk("pslverr", 32'h00000000, 32'(erv));
        chk("prdata", 32'h01234567, rdv);
        apb(1'b0, pld_pkg::A_STATUS, 32'h00000000);
        chk("status", 32'h000100A0, rdv & 32'h000100FF);
        // A second reset clears the fuse and every register
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("io_out", 32'h000000FF, 32'(io_out));
        chk("por_busy", 32'h00000001, 32'(por_busy));
        presetn <= 1'b1;
        repeat (POR + 2) @(posedge pclk);
        apb(1'b0, pld_pkg::A_STATUS, 32'h00000000);
        chk("status", 32'h0000FF00, rdv);
        give_verdict();
    end
endmodule
